// ===== hdl/abh_pkg.sv
`default_nettype none
// shared constants for the ambient brightness hysteresis block
package abh_pkg;
   // profile geometry
   localparam int unsigned STEPS = 16;
   localparam int unsigned STEP_W = 4;
   localparam int unsigned LUM_W = 16;
   localparam int unsigned BRIGHT_W = 8;
   localparam int unsigned GAMMA_W = 4;
   localparam logic [LUM_W-1:0] LUM_TERM = 16'hFFFF;
   localparam logic [STEP_W-1:0] STEP_FIRST = 4'h0;
   localparam logic [STEP_W-1:0] STEP_ONE = 4'h1;

   // median filter: 13 queued samples, 7th smallest (rank 6 from zero)
   localparam int unsigned MED_DEPTH = 13;
   localparam int unsigned RANK_W = 4;
   localparam logic [RANK_W-1:0] MED_RANK = 4'h6;

   // register bus
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned STRB_W = 4;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_OUTPUT = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_LUMA = 8'h0C;
   localparam logic [1:0] BANK_MISC = 2'b00;
   localparam logic [1:0] BANK_PROFILE = 2'b01;
   localparam logic [1:0] BANK_RISE = 2'b10;
   localparam logic [1:0] BANK_FALL = 2'b11;

   // decoded register kinds
   localparam logic [2:0] KIND_NONE = 3'h0;
   localparam logic [2:0] KIND_CTRL = 3'h1;
   localparam logic [2:0] KIND_STATUS = 3'h2;
   localparam logic [2:0] KIND_OUTPUT = 3'h3;
   localparam logic [2:0] KIND_LUMA = 3'h4;
   localparam logic [2:0] KIND_PROFILE = 3'h5;
   localparam logic [2:0] KIND_RISE = 3'h6;
   localparam logic [2:0] KIND_FALL = 3'h7;

   // field positions
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned ST_STEP_LSB = 0;
   localparam int unsigned ST_LAST_LSB = 8;
   localparam int unsigned ST_STATE_LSB = 16;
   localparam int unsigned PROF_GAMMA_LSB = 8;
   localparam int unsigned LUMA_PREV_LSB = 16;

   // values after reset
   localparam logic CTRL_EN_RST = 1'b0;
   localparam logic [BRIGHT_W-1:0] BRIGHT_RST = 8'h00;
   localparam logic [GAMMA_W-1:0] GAMMA_RST = 4'h1;
   localparam logic [LUM_W-1:0] THRESH_RST = 16'hFFFF;
   localparam logic [LUM_W-1:0] LUM_RST = 16'h0000;

   // step selector states, gray along idle -> walk
   typedef enum logic [1:0] {
      ABH_IDLE = 2'b00,
      ABH_UP = 2'b01,
      ABH_DOWN = 2'b10
   } abh_state_e;
endpackage
`default_nettype wire

// ===== hdl/abh_median.sv
`timescale 1ns/1ps
`default_nettype none
module abh_median
   import abh_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [LUM_W-1:0] sample_in,
   input wire logic sample_valid,
   output logic [LUM_W-1:0] median_out,
   output logic median_valid
);
   logic [LUM_W-1:0] queue [MED_DEPTH];
   logic primed;
   logic pending;
   logic [MED_DEPTH-1:0] pick;
   logic [LUM_W-1:0] next_median;

   // population count of a comparison vector
   function automatic logic [RANK_W-1:0] count_ones(input logic [MED_DEPTH-1:0] v);
      logic [RANK_W-1:0] n;
      n = '0;
      for (int k = 0; k < MED_DEPTH; k++) begin
         n = n + RANK_W'(v[k]);
      end
      return n;
   endfunction

   // rank of each entry, ties broken by position
   genvar i, j;
   generate
      for (i = 0; i < MED_DEPTH; i++) begin : g_rank
         logic [MED_DEPTH-1:0] below;
         for (j = 0; j < MED_DEPTH; j++) begin : g_cmp
            assign below[j] = (queue[j] < queue[i]) || ((queue[j] == queue[i]) && (j < i));
         end
         assign pick[i] = (count_ones(below) == MED_RANK);
      end
   endgenerate

   // exactly one entry holds the wanted rank
   always_comb begin
      next_median = '0;
      for (int k = 0; k < MED_DEPTH; k++) begin
         next_median = next_median | (pick[k] ? queue[k] : '0);
      end
   end

   // queue shift; the first sample fills every slot
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int k = 0; k < MED_DEPTH; k++) begin
            queue[k] <= LUM_RST;
         end
         primed <= 1'b0;
      end else if (sample_valid) begin
         primed <= 1'b1;
         for (int k = 0; k < MED_DEPTH - 1; k++) begin
            queue[k] <= primed ? queue[k+1] : sample_in;
         end
         queue[MED_DEPTH-1] <= sample_in;
      end
   end

   // median registered one cycle after the queue settles
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pending <= 1'b0;
         median_out <= LUM_RST;
         median_valid <= 1'b0;
      end else begin
         pending <= sample_valid;
         median_valid <= pending;
         if (pending) begin
            median_out <= next_median;
         end
      end
   end
endmodule // abh_median
`default_nettype wire

// ===== hdl/abh_hysteresis.sv
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module abh_hysteresis
   import abh_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [STRB_W-1:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [LUM_W-1:0] lum_in,
   input wire logic lum_valid,
   output logic [BRIGHT_W-1:0] backlight_level,
   output logic [GAMMA_W-1:0] gamma_sel
);
   // profile storage
   logic [BRIGHT_W-1:0] bright [STEPS];
   logic [GAMMA_W-1:0] gamma [STEPS];
   logic [LUM_W-1:0] rise [STEPS];
   logic [LUM_W-1:0] fall [STEPS];
   logic ctrl_en;

   // bus state
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [DATA_W-1:0] w_data;
   logic [STRB_W-1:0] w_strb;
   logic [DATA_W-1:0] rd_word;

   // selector state
   abh_state_e state;
   abh_state_e next_state;
   logic [STEP_W-1:0] step_idx;
   logic [STEP_W-1:0] next_step;
   logic [STEP_W-1:0] last_step;
   logic [STEPS-1:0] is_term;
   logic [LUM_W-1:0] cur_lum;
   logic [LUM_W-1:0] prev_lum;
   logic [LUM_W-1:0] med_lum;
   logic med_valid;

   // register kind from a byte address
   function automatic logic [2:0] reg_kind(input logic [ADDR_W-1:0] a);
      logic [2:0] k;
      k = KIND_NONE;
      if (a[1:0] == 2'b00) begin
         unique case (a[7:6])
            BANK_PROFILE: k = KIND_PROFILE;
            BANK_RISE: k = KIND_RISE;
            BANK_FALL: k = KIND_FALL;
            BANK_MISC: begin
               if (a == OFS_CTRL) k = KIND_CTRL;
               else if (a == OFS_STATUS) k = KIND_STATUS;
               else if (a == OFS_OUTPUT) k = KIND_OUTPUT;
               else if (a == OFS_LUMA) k = KIND_LUMA;
            end
         endcase
      end
      return k;
   endfunction

   // byte-lane merge of a write into the old word
   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                               input logic [DATA_W-1:0] nw,
                                               input logic [STRB_W-1:0] strb);
      logic [DATA_W-1:0] m;
      m = old;
      for (int b = 0; b < STRB_W; b++) begin
         if (strb[b]) m[b*8 +: 8] = nw[b*8 +: 8];
      end
      return m;
   endfunction

   // median filter in front of the selector
   abh_median u_median (
      .aclk(aclk),
      .aresetn(aresetn),
      .sample_in(lum_in),
      .sample_valid(lum_valid),
      .median_out(med_lum),
      .median_valid(med_valid)
   );

   // write channel acceptance, either order
   assign awready = !aw_held && !bvalid;
   assign wready = !w_held && !bvalid;
   wire do_write = aw_held && w_held && !bvalid;
   wire [2:0] wr_kind = reg_kind(aw_addr);
   wire [STEP_W-1:0] wr_idx = aw_addr[2 +: STEP_W];

   // merged words for the profile, rise and fall kinds
   wire [DATA_W-1:0] prof_old = {{(DATA_W-PROF_GAMMA_LSB-GAMMA_W){1'b0}}, gamma[wr_idx],
                                 bright[wr_idx]};
   wire [DATA_W-1:0] prof_new = merge(prof_old, w_data, w_strb);
   wire [DATA_W-1:0] rise_new = merge({{(DATA_W-LUM_W){1'b0}}, rise[wr_idx]}, w_data, w_strb);
   wire [DATA_W-1:0] fall_new = merge({{(DATA_W-LUM_W){1'b0}}, fall[wr_idx]}, w_data, w_strb);

   // write address/data capture and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr <= awaddr;
         end
         if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b1;
            bresp <= (wr_kind == KIND_NONE) ? RESP_SLVERR : RESP_OKAY;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_en <= CTRL_EN_RST;
      end else if (do_write && wr_kind == KIND_CTRL && w_strb[0]) begin
         ctrl_en <= w_data[CTRL_EN_BIT];
      end
   end

   // profile storage writes, one step per word
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int k = 0; k < STEPS; k++) begin
            bright[k] <= BRIGHT_RST;
            gamma[k] <= GAMMA_RST;
            rise[k] <= THRESH_RST;
            fall[k] <= THRESH_RST;
         end
      end else if (do_write) begin
         if (wr_kind == KIND_PROFILE) begin
            bright[wr_idx] <= prof_new[0 +: BRIGHT_W];
            gamma[wr_idx] <= prof_new[PROF_GAMMA_LSB +: GAMMA_W];
         end
         if (wr_kind == KIND_RISE) begin
            rise[wr_idx] <= rise_new[LUM_W-1:0];
         end
         if (wr_kind == KIND_FALL) begin
            fall[wr_idx] <= fall_new[LUM_W-1:0];
         end
      end
   end

   // read mux
   wire [2:0] rd_kind = reg_kind(araddr);
   wire [STEP_W-1:0] rd_idx = araddr[2 +: STEP_W];
   always_comb begin
      rd_word = '0;
      unique case (rd_kind)
         KIND_CTRL: rd_word[CTRL_EN_BIT] = ctrl_en;
         KIND_STATUS: begin
            rd_word[ST_STEP_LSB +: STEP_W] = step_idx;
            rd_word[ST_LAST_LSB +: STEP_W] = last_step;
            rd_word[ST_STATE_LSB +: 2] = state;
         end
         KIND_OUTPUT: begin
            rd_word[0 +: BRIGHT_W] = backlight_level;
            rd_word[PROF_GAMMA_LSB +: GAMMA_W] = gamma_sel;
         end
         KIND_LUMA: begin
            rd_word[0 +: LUM_W] = cur_lum;
            rd_word[LUMA_PREV_LSB +: LUM_W] = prev_lum;
         end
         KIND_PROFILE: begin
            rd_word[0 +: BRIGHT_W] = bright[rd_idx];
            rd_word[PROF_GAMMA_LSB +: GAMMA_W] = gamma[rd_idx];
         end
         KIND_RISE: rd_word[0 +: LUM_W] = rise[rd_idx];
         KIND_FALL: rd_word[0 +: LUM_W] = fall[rd_idx];
         KIND_NONE: rd_word = '0;
      endcase
   end

   // read channel
   assign arready = !rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata <= rd_word;
         rresp <= (rd_kind == KIND_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   // terminator flags; the sixteenth step always terminates
   genvar s;
   generate
      for (s = 0; s < STEPS; s++) begin : g_term
         if (s == STEPS - 1) begin : g_last
            assign is_term[s] = 1'b1;
         end else begin : g_used
            assign is_term[s] = (rise[s] == LUM_TERM) && (fall[s] == LUM_TERM);
         end
      end
   endgenerate

   // first terminator is the top of the profile
   always_comb begin
      last_step = STEP_FIRST;
      for (int k = STEPS - 1; k >= 0; k--) begin
         if (is_term[k]) last_step = STEP_W'(k);
      end
   end

   // walk conditions against the current reference
   wire [STEP_W-1:0] step_below = step_idx - STEP_ONE;
   wire over_top = step_idx > last_step;
   wire up_ok = (step_idx < last_step) && (cur_lum > rise[step_idx]);
   wire down_ok = (step_idx != STEP_FIRST) && (cur_lum < fall[step_below]);

   // step selector, one step per cycle when walking, straight down to the top step when idle above it
   always_comb begin
      next_state = state;
      next_step = step_idx;
      unique case (state)
         ABH_IDLE: begin
            if (over_top) next_step = last_step;
         end
         ABH_UP: begin
            if (over_top) next_step = step_below;
            else if (up_ok) next_step = step_idx + STEP_ONE;
            else next_state = ABH_IDLE;
         end
         ABH_DOWN: begin
            if (over_top) next_step = step_below;
            else if (down_ok) next_step = step_below;
            else next_state = ABH_IDLE;
         end
         default: next_state = ABH_IDLE;
      endcase
      // a new reference restarts the walk in its direction
      if (med_valid) begin
         if (med_lum > cur_lum) next_state = ABH_UP;
         else if (med_lum < cur_lum) next_state = ABH_DOWN;
         else next_state = ABH_IDLE;
      end
      if (!ctrl_en) next_state = ABH_IDLE;
   end

   // selector registers and luminance history
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ABH_IDLE;
         step_idx <= STEP_FIRST;
         cur_lum <= LUM_RST;
         prev_lum <= LUM_RST;
      end else begin
         state <= next_state;
         step_idx <= next_step;
         if (med_valid) begin
            prev_lum <= cur_lum;
            cur_lum <= med_lum;
         end
      end
   end

   // outputs follow the selected step
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         backlight_level <= BRIGHT_RST;
         gamma_sel <= GAMMA_RST;
      end else begin
         backlight_level <= bright[step_idx];
         gamma_sel <= gamma[step_idx];
      end
   end
endmodule // abh_hysteresis
`default_nettype wire

// ===== bench/abh_checker_props.sv
`timescale 1ns/1ps
`default_nettype none
module abh_checker
   import abh_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic lum_valid,
   input wire logic [BRIGHT_W-1:0] backlight_level,
   input wire logic [GAMMA_W-1:0] gamma_sel
);
   logic [7:0] quiet;
   // cycles since the last sample or register write
   always_ff @(posedge aclk) begin
      if (!aresetn || lum_valid || (awvalid && awready)) begin
         quiet <= 8'h00;
      end else if (quiet != 8'hFF) begin
         quiet <= quiet + 8'h01;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_b_hold: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped early");
   chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer changed before taken");
   chk_r_cause: assert property ($rose(rvalid) |-> $past(arvalid && arready))
      else $error("read answer without a taken request");
   chk_r_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   chk_b_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("write answer late");
   chk_w_block: assert property ($rose(bvalid) |-> $past(!awready && !wready))
      else $error("write accepted while write in progress");
   chk_gamma_hot: assert property ($onehot(gamma_sel))
      else $error("gamma select not one-hot");
   chk_bad_addr: assert property (arvalid && arready && araddr[7:4] == 4'h1 |=> rresp == RESP_SLVERR)
      else $error("unmapped read not refused");
   chk_out_cause: assert property ($changed(backlight_level) |-> quiet < 8'h28)
      else $error("backlight changed without cause");
   cov_write: cover property (bvalid && bready);
   cov_read: cover property (rvalid && rready);
   cov_level: cover property ($changed(backlight_level));
endmodule // abh_checker
bind abh_hysteresis abh_checker u_chk(.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
   .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
   .rvalid(rvalid), .rready(rready), .lum_valid(lum_valid),
   .backlight_level(backlight_level), .gamma_sel(gamma_sel));
`default_nettype wire

// ===== bench/abh_lum_src.sv
`timescale 1ns/1ps
`default_nettype none
module abh_lum_src
   import abh_pkg::*;
(
   input wire logic aclk,
   output logic [LUM_W-1:0] lum_in,
   output logic lum_valid
);
   // idle until the first sample
   initial begin
      lum_in = 16'h0000;
      lum_valid = 1'b0;
   end
   // one-cycle sample strobe; idle bus shows the inverse, gap sets the pace
   task automatic send(input logic [LUM_W-1:0] v, input int gap);
      @(posedge aclk);
      lum_in <= v;
      lum_valid <= 1'b1;
      @(posedge aclk);
      lum_in <= ~v;
      lum_valid <= 1'b0;
      repeat (gap) @(posedge aclk);
   endtask
endmodule // abh_lum_src
`default_nettype wire

// ===== bench/test_ambient_brightness_hysteresis.sv
`timescale 1ns/1ps
`default_nettype none
module test_ambient_brightness_hysteresis
   import abh_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, lum_valid;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic [15:0] lum_in;
   logic [7:0] backlight_level;
   logic [3:0] gamma_sel;
   int err_count = 0, tests_run = 0, i;
   logic [15:0] med_q [13] = '{16'hA000, 16'h7800, 16'hFA00, 16'h8000, 16'hF500, 16'hB900,
      16'hC800, 16'hE600, 16'hD200, 16'hA000, 16'h9600, 16'hC800, 16'hB900};
   logic [15:0] rise0 [6] = '{16'h0F00, 16'h4200, 16'h6400, 16'h8C00, 16'hBF00, 16'hFFFF};
   logic [15:0] fall0 [6] = '{16'h0A00, 16'h3800, 16'h5000, 16'h8200, 16'hAB00, 16'hFFFF};

   always #12.5 aclk = ~aclk;

   abh_hysteresis u_abh_hysteresis(.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .lum_in(lum_in), .lum_valid(lum_valid),
      .backlight_level(backlight_level), .gamma_sel(gamma_sel));
   abh_lum_src u_lum(.aclk(aclk), .lum_in(lum_in), .lum_valid(lum_valid));

   // profile word of step n: one-hot gamma, brightness
   function automatic logic [31:0] outw(input int n);
      logic [7:0] b;
      b = 8'h10 * 8'(n) + 8'h05;
      return {20'h0_0000, 4'h1 << n[1:0], b};
   endfunction

   // comparison, timeout and verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
         err_count++;
      end
   endtask
   task automatic guard(input int n);
      if (n >= 50) begin
         $display("CHECK FAILED at %0t: bus timeout", $time);
         err_count++;
         test_done();
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // bus master cycles
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      logic ad;
      logic wd;
      n = 0;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd) && n < 50) begin
         @(posedge aclk);
         n++;
         if (!ad && awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wd && wready) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do begin
         @(posedge aclk);
         n++;
      end while (!bvalid && n < 50);
      rs = bresp;
      bready <= 1'b0;
      guard(n);
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (!arready && n < 50);
      arvalid <= 1'b0;
      do begin
         @(posedge aclk);
         n++;
      end while (!rvalid && n < 50);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
      guard(n);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      logic [1:0] rs;
      axi_wr(a, v, rs);
      chk({30'h0, rs}, {30'h0, er});
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      logic [1:0] rs;
      axi_rd(a, v, rs);
      chk(v, e);
      chk({30'h0, rs}, 32'h0000_0000);
   endtask
   task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] v;
      logic [1:0] rs;
      for (int k = 0; k < 60; k++) begin
         axi_rd(a, v, rs);
         if ((v & m) === e) break;
      end
      chk(v & m, e);
      if ((v & m) !== e) test_done();
   endtask
   // seven samples make v the median, then the walk settles
   task automatic step_is(input logic [15:0] v, input int n);
      logic [31:0] v32;
      logic [1:0] rs;
      repeat (7) u_lum.send(v, 1);
      poll(OFS_LUMA, 32'h0000_FFFF, {16'h0000, v});
      repeat (20) @(posedge aclk);
      axi_rd(OFS_STATUS, v32, rs);
      chk(v32 & 32'h0000_000F, 32'(n));
      chk({20'h0_0000, gamma_sel, backlight_level}, outw(n));
      $display("test done: level %0d", n);
   endtask

   // main sequence
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(OFS_CTRL, 32'h0000_0000);
      rdc(OFS_STATUS, 32'h0000_0000);
      rdc(OFS_OUTPUT, {20'h0_0000, GAMMA_RST, BRIGHT_RST});
      rdc(8'h80, {16'h0000, THRESH_RST});
      rdc(8'hFC, {16'h0000, THRESH_RST});
      axi_rd(8'h10, d, r);
      chk(d, 32'h0000_0000);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      wr(8'h20, 32'h0000_0001, RESP_SLVERR);
      wr(OFS_STATUS, 32'h0000_000F, RESP_OKAY);
      rdc(OFS_STATUS, 32'h0000_0000);
      $display("test done: reset and map");
      foreach (med_q[k]) u_lum.send(med_q[k], 0);
      poll(OFS_LUMA, 32'h0000_FFFF, 32'h0000_B900);
      u_lum.send(16'hC800, 3);
      poll(OFS_LUMA, 32'h0000_FFFF, 32'h0000_C800);
      rdc(OFS_STATUS, 32'h0000_0000);
      $display("test done: median");
      for (i = 0; i < 16; i++) wr(8'(8'h40 + 4 * i), outw(i), RESP_OKAY);
      for (i = 0; i < 6; i++) begin
         wr(8'(8'h80 + 4 * i), {16'h0000, rise0[i]}, RESP_OKAY);
         wr(8'(8'hC0 + 4 * i), {16'h0000, fall0[i]}, RESP_OKAY);
      end
      wr(8'h98, 32'h0000_0010, RESP_OKAY);
      wr(8'hD8, 32'h0000_0008, RESP_OKAY);
      rdc(OFS_STATUS, 32'h0000_0500);
      repeat (13) u_lum.send(16'h0000, 1);
      poll(OFS_LUMA, 32'h0000_FFFF, 32'h0000_0000);
      wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
      step_is(16'h7000, 3);
      step_is(16'h8400, 3);
      step_is(16'h8300, 3);
      step_is(16'h0100, 0);
      step_is(16'hFFF0, 5);
      for (i = 5; i < 16; i++) begin
         wr(8'(8'h80 + 4 * i), 32'(32'h0000_C000 + 32'h100 * i), RESP_OKAY);
         wr(8'(8'hC0 + 4 * i), 32'(32'h0000_BF80 + 32'h100 * i), RESP_OKAY);
      end
      poll(OFS_STATUS, 32'h0000_0F0F, 32'h0000_0F05);
      step_is(16'hFFFE, 15);
      rdc(8'hBC, 32'h0000_CF00);
      // reset in mid-run returns to the first step and an empty history
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(OFS_STATUS, 32'h0000_0000);
      rdc(OFS_LUMA, 32'h0000_0000);
      rdc(OFS_OUTPUT, {20'h0_0000, GAMMA_RST, BRIGHT_RST});
      // single-lane write: only the gamma byte of step 0 changes
      wstrb <= 4'h2;
      wr(8'h40, 32'h0000_08F5, RESP_OKAY);
      wstrb <= 4'hF;
      rdc(8'h40, 32'h0000_0800);
      rdc(OFS_OUTPUT, 32'h0000_0800);
      $display("test done: reset in run and strobes");
      test_done();
   end
endmodule // test_ambient_brightness_hysteresis
`default_nettype wire
